// >>> rtl/uart_rx_ctrl.sv
// serial receiver with the shared status, control and data registers of the uart
// assumes an axi4-lite master, a transmit shift path outside and synchronous pin inputs
//
// The AXI4-Lite register port is this design's own decision.
`include "uart_rx_ctrl_consts.svh"

// Summary of operation
// - receive pin is sampled sixteen times per bit period
// - one low sample while idle starts start-bit checking, counted sample one
// - start bit dropped as noise if two of samples 8, 9, 10 are high
// - each data bit is the majority of samples 8, 9 and 10
// - stop bit accepted on high majority, otherwise framing fault flag sets
// - framing fault flag clears when a stop bit samples high
// - each finished character goes to a free receive buffer and sets done flag
// - data register reads receive holding, writes transmit holding register
// - nine-bit mode loads received ninth bit when buffer is loaded
// - character finishing over an unread buffer sets overrun and is dropped
// - overrun becomes visible on buffer read, clears on accepted character
// - enabled receiver forces pin to input; pull-up latch still works
// - disabled receiver sets no receive flags and keeps set ones
// - buffer read clears done flag; done with enables requests interrupt
// - transmit done sets after last stop bit; cleared by vector or one
// - buffer-empty sets on shift load, clears on data write, set at reset
// - buffer-empty interrupt requested while flag, its enable and global enable set
// - clearing transmit enable waits until shift and holding drain
// - nine-bit mode carries nine data bits with one start, one stop
// - status bits 2 to 0 read zero; bits 7 to 3 hold flags
// - control bits 7, 6, 5 gate the three interrupts with global enable
// - sample rate is core clock over baud divisor plus one
// - data bits arrive least significant first after the start bit
module uart_rx_ctrl
  import uart_rx_ctrl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        rx_pin_in,
  input  wire logic        direction_bit_0,
  input  wire logic        pullup_latch_bit,
  input  wire logic        global_irq_enable,
  input  wire logic        tx_shift_load,
  input  wire logic        tx_char_sent,
  input  wire logic        tx_vector_ack,
  input  wire logic        tx_shift_busy,

  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,

  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,

  output logic             rx_done_irq,
  output logic             tx_done_irq,
  output logic             tx_empty_irq,

  output logic             pin_oe,
  output logic             pin_out,
  output logic             pin_pullup,

  output logic [7:0]       tx_hold_data,
  output logic             tx_hold_ninth,
  output logic             tx_data_pending,
  output logic             tx_active,
  output logic             sample_tick
);

  // ****************************************
  // state
  // ****************************************
  state_t     s_reg;
  state_t     s_next;

  logic       maj;
  logic       complete;
  logic       stop_ok;
  logic       wr_fire;
  logic       wr_en;
  logic       rd_fire;
  logic       rd_data_buf;
  logic       wr_data_buf;
  logic [3:0] char_bits;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next      = s_reg;
    complete    = 1'b0;
    stop_ok     = 1'b0;
    wr_fire     = s_reg.awready && s_reg.wready;
    wr_en       = wr_fire && s_axi_wstrb[0];
    rd_fire     = s_reg.arready;
    rd_data_buf = rd_fire && (s_axi_araddr == `DATA_ADDR);
    wr_data_buf = wr_en && (s_axi_awaddr == `DATA_ADDR);
    char_bits   = s_reg.ctrl[`CTRL_NINE_BIT] ? `BITS_NINE : `BITS_EIGHT;
    maj         = (s_reg.votes[1] & s_reg.votes[0]) | (s_reg.votes[1] & rx_pin_in)
                | (s_reg.votes[0] & rx_pin_in);

    // sample tick: one every baud_divisor+1 clocks, sixteen per bit
    s_next.tick    = (s_reg.div_cnt == s_reg.baud_div);
    s_next.div_cnt = s_next.tick ? 8'h00 : s_reg.div_cnt + 8'h01;

    // receiver; a disabled receiver abandons any character in flight
    if (!s_reg.ctrl[`CTRL_RX_EN]) begin
      s_next.rx_state = RX_IDLE;
    end else if (s_reg.tick) begin
      s_next.smp_cnt = s_reg.smp_cnt + 4'h1;
      // samples 8 and 9 are kept; the live pin is the third vote at sample 10
      if (s_reg.smp_cnt == `SMP_VOTE_A || s_reg.smp_cnt == `SMP_VOTE_B) begin
        s_next.votes = {s_reg.votes[0], rx_pin_in};
      end
      unique case (s_reg.rx_state)
        RX_IDLE: begin
          // count restarts while idle, so the first low sample is sample one
          s_next.smp_cnt = `SMP_SECOND;
          if (rx_pin_in) begin
            s_next.smp_cnt = `SMP_FIRST;
          end else begin
            s_next.rx_state = RX_START;
          end
        end

        RX_START: begin
          if (s_reg.smp_cnt == `SMP_DECIDE) begin
            if (maj) begin
              s_next.rx_state = RX_IDLE;
            end else begin
              s_next.rx_state = RX_DATA;
              s_next.bit_cnt  = 4'h0;
            end
          end
        end

        RX_DATA: begin
          if (s_reg.smp_cnt == `SMP_DECIDE) begin
            s_next.shift[s_reg.bit_cnt] = maj;
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
            if (s_reg.bit_cnt == char_bits - 4'h1) begin
              s_next.rx_state = RX_STOP;
            end
          end
        end

        RX_STOP: begin
          if (s_reg.smp_cnt == `SMP_DECIDE) begin
            complete        = 1'b1;
            stop_ok         = maj;
            s_next.rx_state = RX_IDLE;
          end
        end

        default: begin
          s_next.rx_state = RX_IDLE;
        end
      endcase
    end

    // reading the buffer frees it and reveals a held overrun
    if (rd_data_buf) begin
      s_next.rx_done      = 1'b0;
      s_next.overrun      = s_reg.overrun_pend;
      s_next.overrun_pend = 1'b0;
    end

    // a character finishing in the same cycle as the read finds the buffer free
    if (complete) begin
      s_next.framing = !stop_ok;
      if (s_reg.rx_done && !rd_data_buf) begin
        s_next.overrun_pend = 1'b1;
      end else begin
        s_next.rx_buf  = s_reg.shift[7:0];
        s_next.rx_done = 1'b1;
        s_next.overrun = 1'b0;
        if (s_reg.ctrl[`CTRL_NINE_BIT]) begin
          s_next.rx_ninth = s_reg.shift[8];
        end
      end
    end

    // transmit side flags; hardware sets win over clears
    if (wr_data_buf) begin
      s_next.tx_hold  = s_axi_wdata[7:0];
      s_next.tx_empty = 1'b0;
    end

    if (tx_shift_load) begin
      s_next.tx_empty = 1'b1;
    end

    if (tx_vector_ack || (wr_en && s_axi_awaddr == `STAT_ADDR && s_axi_wdata[`STAT_TX_DONE])) begin
      s_next.tx_done = 1'b0;
    end

    if (tx_char_sent) begin
      s_next.tx_done = 1'b1;
    end

    // register writes
    if (wr_en && s_axi_awaddr == `CTRL_ADDR) begin
      s_next.ctrl = s_axi_wdata[7:0];
      s_next.ctrl[`CTRL_RX_NINTH] = 1'b0;
    end

    if (wr_en && s_axi_awaddr == `BAUD_ADDR) begin
      s_next.baud_div = s_axi_wdata[7:0];
    end

    // write channel: both address and data are taken together
    s_next.awready = s_axi_awvalid && s_axi_wvalid && !s_reg.awready && !s_reg.bvalid;
    s_next.wready  = s_next.awready;

    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    if (wr_fire) begin
      s_next.bvalid = 1'b1;
      s_next.bresp  = `RESP_OKAY;
      if (s_axi_awaddr != `DATA_ADDR && s_axi_awaddr != `CTRL_ADDR
          && s_axi_awaddr != `STAT_ADDR && s_axi_awaddr != `BAUD_ADDR) begin
        s_next.bresp = `RESP_SLVERR;
      end
    end

    // read channel
    s_next.arready = s_axi_arvalid && !s_reg.arready && !s_reg.rvalid;

    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end

    if (rd_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = `RESP_OKAY;
      s_next.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        `DATA_ADDR: s_next.rdata[7:0] = s_reg.rx_buf;
        `CTRL_ADDR: s_next.rdata[7:0] = {s_reg.ctrl[7:2], s_reg.rx_ninth, 1'b0};
        `STAT_ADDR: s_next.rdata[7:0] = {s_reg.rx_done, s_reg.tx_done, s_reg.tx_empty,
                                         s_reg.framing, s_reg.overrun, 3'h0};
        `BAUD_ADDR: s_next.rdata[7:0] = s_reg.baud_div;
        default:    s_next.rresp = `RESP_SLVERR;
      endcase
    end

    // interrupt requests stand while flag, enable and global enable stand
    s_next.rx_irq  = s_next.rx_done && s_next.ctrl[`CTRL_RX_IRQ_EN] && global_irq_enable;
    s_next.txd_irq = s_next.tx_done && s_next.ctrl[`CTRL_TXD_IRQ_EN] && global_irq_enable;
    s_next.txe_irq = s_next.tx_empty && s_next.ctrl[`CTRL_TXE_IRQ_EN] && global_irq_enable;

    // pin: receiver overrides direction, pull-up latch stays in charge
    s_next.pin_oe     = !s_next.ctrl[`CTRL_RX_EN] && direction_bit_0;
    s_next.pin_out    = pullup_latch_bit;
    s_next.pin_pullup = pullup_latch_bit && !s_next.pin_oe;

    // transmitter stays on until both holding and shift register drain
    s_next.tx_active = s_next.ctrl[`CTRL_TX_EN] || !s_next.tx_empty || tx_shift_busy;
    s_next.tx_pending = !s_next.tx_empty;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_reg          <= '0;
      s_reg.rx_state <= RX_IDLE;
      s_reg.ctrl     <= `CTRL_RESET;
      s_reg.baud_div <= `BAUD_RESET;
      s_reg.tx_empty <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready   = s_reg.awready;
  assign s_axi_wready    = s_reg.wready;
  assign s_axi_bresp     = s_reg.bresp;
  assign s_axi_bvalid    = s_reg.bvalid;
  assign s_axi_arready   = s_reg.arready;
  assign s_axi_rdata     = s_reg.rdata;
  assign s_axi_rresp     = s_reg.rresp;
  assign s_axi_rvalid    = s_reg.rvalid;

  assign rx_done_irq     = s_reg.rx_irq;
  assign tx_done_irq     = s_reg.txd_irq;
  assign tx_empty_irq    = s_reg.txe_irq;

  assign pin_oe          = s_reg.pin_oe;
  assign pin_out         = s_reg.pin_out;
  assign pin_pullup      = s_reg.pin_pullup;

  assign tx_hold_data    = s_reg.tx_hold;
  assign tx_hold_ninth   = s_reg.ctrl[`CTRL_TX_NINTH];
  assign tx_data_pending = s_reg.tx_pending;
  assign tx_active       = s_reg.tx_active;
  assign sample_tick     = s_reg.tick;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_baud_wrap: assert property (s_reg.tick |-> s_reg.div_cnt == 8'h00)
    else $error("sample tick not aligned with divider wrap");

  a_start_reject: assert property (
    s_reg.ctrl[`CTRL_RX_EN] && s_reg.tick && s_reg.rx_state == RX_START
    && s_reg.smp_cnt == `SMP_DECIDE && maj |=> s_reg.rx_state == RX_IDLE)
    else $error("noisy start bit not rejected");

  a_start_begin: assert property (
    s_reg.ctrl[`CTRL_RX_EN] && s_reg.tick && s_reg.rx_state == RX_IDLE && !rx_pin_in
    |=> s_reg.rx_state == RX_START && s_reg.smp_cnt == `SMP_SECOND)
    else $error("falling edge not taken as start");

  a_frame_flag: assert property (complete |=> s_reg.framing == !$past(stop_ok))
    else $error("framing flag does not follow stop bit");

  a_rx_accept: assert property (complete && !s_reg.rx_done |=> s_reg.rx_done && !s_reg.overrun)
    else $error("accepted character not flagged");

  a_overrun_drop: assert property (
    complete && s_reg.rx_done && !rd_data_buf |=> $stable(s_reg.rx_buf) && s_reg.overrun_pend)
    else $error("overrun character not dropped");

  a_overrun_show: assert property (rd_data_buf && !complete
    |=> s_reg.overrun == $past(s_reg.overrun_pend))
    else $error("held overrun not shown on buffer read");

  a_rx_quiet: assert property (!s_reg.ctrl[`CTRL_RX_EN] && !s_reg.rx_done |=> !s_reg.rx_done)
    else $error("disabled receiver set done flag");

  a_read_clear: assert property (rd_data_buf && !complete |=> !s_reg.rx_done)
    else $error("buffer read left done flag set");

  a_pin_input: assert property (s_reg.ctrl[`CTRL_RX_EN] |-> !s_reg.pin_oe)
    else $error("enabled receiver left pin driven");

  // ****************************************
  // register and transmit checks
  // ****************************************
  a_empty_clear: assert property (wr_data_buf && !tx_shift_load |=> !s_reg.tx_empty)
    else $error("data write left empty flag set");

  a_empty_set: assert property (tx_shift_load |=> s_reg.tx_empty)
    else $error("shift load left empty flag clear");

  a_txd_set: assert property (tx_char_sent |=> s_reg.tx_done ##1 (s_reg.txd_irq
    == (s_reg.tx_done && s_reg.ctrl[`CTRL_TXD_IRQ_EN] && $past(global_irq_enable))))
    else $error("transmit done flag or request wrong");

  a_txd_clear: assert property (tx_vector_ack && !tx_char_sent |=> !s_reg.tx_done)
    else $error("vector left transmit done flag set");

  a_status_zero: assert property (rd_fire && s_axi_araddr == `STAT_ADDR
    |=> s_reg.rvalid && s_reg.rdata[2:0] == 3'h0)
    else $error("reserved status bits not zero");

  a_tx_hold_on: assert property (!s_reg.tx_empty && !tx_shift_load |=> s_reg.tx_active)
    else $error("transmitter dropped with data pending");

endmodule // uart_rx_ctrl

// >>> rtl/uart_rx_ctrl_consts.svh
// constants of the serial receiver and its control registers
// assumes a 25 MHz core clock and byte addresses of four times the register index
`ifndef UART_RX_CTRL_CONSTS_SVH
`define UART_RX_CTRL_CONSTS_SVH

// ****************************************
// register indices and byte addresses
// ****************************************
`define BAUD_IDX        6'h09
`define CTRL_IDX        6'h0a
`define STAT_IDX        6'h0b
`define DATA_IDX        6'h0c
`define BAUD_ADDR       {`BAUD_IDX, 2'b00}
`define CTRL_ADDR       {`CTRL_IDX, 2'b00}
`define STAT_ADDR       {`STAT_IDX, 2'b00}
`define DATA_ADDR       {`DATA_IDX, 2'b00}

// ****************************************
// field positions
// ****************************************
`define CTRL_RX_IRQ_EN  7
`define CTRL_TXD_IRQ_EN 6
`define CTRL_TXE_IRQ_EN 5
`define CTRL_RX_EN      4
`define CTRL_TX_EN      3
`define CTRL_NINE_BIT   2
`define CTRL_RX_NINTH   1
`define CTRL_TX_NINTH   0
`define STAT_TX_DONE    6

// ****************************************
// reset values and answers
// ****************************************
`define CTRL_RESET      8'h00
`define BAUD_RESET      8'h00
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ****************************************
// oversampling counts (16 samples a bit)
// ****************************************
`define SMP_VOTE_A      4'h7
`define SMP_VOTE_B      4'h8
`define SMP_DECIDE      4'h9
`define SMP_FIRST       4'h0
`define SMP_SECOND      4'h1
`define BITS_EIGHT      4'h8
`define BITS_NINE       4'h9

`endif

// >>> rtl/uart_rx_ctrl_pkg.sv
// types of the serial receiver and its control registers
// assumes nothing beyond a SystemVerilog compiler
package uart_rx_ctrl_pkg;

  // ****************************************
  // receiver states
  // ****************************************
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_t;

  // ****************************************
  // whole state of the block
  // ****************************************
  typedef struct packed {
    rx_state_t   rx_state;
    logic [7:0]  div_cnt;
    logic        tick;
    logic [3:0]  smp_cnt;
    logic [1:0]  votes;
    logic [3:0]  bit_cnt;
    logic [8:0]  shift;
    logic [7:0]  rx_buf;
    logic [7:0]  tx_hold;
    logic [7:0]  baud_div;
    logic [7:0]  ctrl;
    logic        rx_ninth;
    logic        rx_done;
    logic        tx_done;
    logic        tx_empty;
    logic        framing;
    logic        overrun;
    logic        overrun_pend;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rx_irq;
    logic        txd_irq;
    logic        txe_irq;
    logic        pin_oe;
    logic        pin_out;
    logic        pin_pullup;
    logic        tx_active;
    logic        tx_pending;
  } state_t;

endpackage

// >>> verification/uart_remote_tx.sv
// remote asynchronous transmitter that drives the receive line of the uart
// assumes the bench gives the bit length in core clocks and calls the tasks after an edge
module uart_remote_tx (
  input  wire logic ref_clk,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // framing
  // ****************************************
  initial line = 1'b1;
  // start bit, data lsb first, then the chosen stop level; idle high after
  task automatic send(input logic [8:0] data, input int nbits, input logic stop_val, input int bit_clks);
    for (int i = -1; i <= nbits; i++) begin
      @(posedge ref_clk);
      if (i < 0)
        line <= 1'b0;
      else if (i == nbits)
        line <= stop_val;
      else
        line <= data[i];
      repeat (bit_clks - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    line <= 1'b1;
    // long idle so a low stop level is rejected as noise before the next frame
    repeat (2 * bit_clks) @(posedge ref_clk);
  endtask
  // short low spike, shorter than half a bit
  task automatic glitch(input int n);
    @(posedge ref_clk);
    line <= 1'b0;
    repeat (n) @(posedge ref_clk);
    line <= 1'b1;
    repeat (64) @(posedge ref_clk);
  endtask
endmodule // uart_remote_tx

// >>> verification/uart_rx_ctrl_tb.sv
// self-checking bench of the serial receiver and its registers
// assumes the design's consts header and an axi4-lite master of its own
`include "uart_rx_ctrl_consts.svh"
module uart_rx_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT_CLKS = 32; // divisor 1: tick every 2 clocks, 16 ticks a bit
  logic        ref_clk, sys_rst, direction_bit_0, pullup_latch_bit, global_irq_enable;
  logic        tx_shift_load, tx_char_sent, tx_vector_ack, tx_shift_busy, rx_line;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, b, tx_hold_data;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        rx_done_irq, tx_done_irq, tx_empty_irq, pin_oe, pin_pullup, tx_active;
  logic        pin_out, tx_hold_ninth, tx_data_pending, sample_tick;
  int          n_mismatch, n_compared, n_tick;

  uart_remote_tx rmt (.ref_clk(ref_clk), .line(rx_line));
  uart_rx_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .rx_pin_in(rx_line), .direction_bit_0(direction_bit_0),
    .pullup_latch_bit(pullup_latch_bit), .global_irq_enable(global_irq_enable), .tx_shift_load(tx_shift_load),
    .tx_char_sent(tx_char_sent), .tx_vector_ack(tx_vector_ack), .tx_shift_busy(tx_shift_busy),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rx_done_irq(rx_done_irq), .tx_done_irq(tx_done_irq), .tx_empty_irq(tx_empty_irq), .pin_oe(pin_oe),
    .pin_out(pin_out), .pin_pullup(pin_pullup), .tx_hold_data(tx_hold_data), .tx_hold_ninth(tx_hold_ninth),
    .tx_data_pending(tx_data_pending), .tx_active(tx_active), .sample_tick(sample_tick));

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [7:0] st(input logic rx_done_flag, tx_done_flag, tx_buffer_empty_flag, fe, ovr);
    return {rx_done_flag, tx_done_flag, tx_buffer_empty_flag, fe, ovr, 3'b000};
  endfunction

  // ****************************************
  // bus master
  // ****************************************
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, v};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) begin
      check("write handshake", 32'h0, 32'h1);
      wrap_up();
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) begin
      check("read handshake", 32'h0, 32'h1);
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [1:0] rs;
    axi_wr(a, v, rs);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [31:0] v;
    logic [1:0]  rs;
    axi_rd(a, v, rs);
    check(what, v, {24'h0, exp});
  endtask
  // one-cycle pulse on a transmit-side event: 0 load, 1 sent, 2 vector
  task automatic pulse(input int k);
    @(posedge ref_clk);
    tx_shift_load <= (k == 0);
    tx_char_sent <= (k == 1);
    tx_vector_ack <= (k == 2);
    @(posedge ref_clk);
    tx_shift_load <= 1'b0;
    tx_char_sent <= 1'b0;
    tx_vector_ack <= 1'b0;
  endtask

  // ****************************************
  // clock, watchdog and tests
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #(40 * 90000);
    check("run length", 32'h0, 32'h1);
    wrap_up();
  end
  initial begin
    {sys_rst, direction_bit_0, pullup_latch_bit} = 3'b111;
    {global_irq_enable, tx_shift_load, tx_char_sent, tx_vector_ack, tx_shift_busy} = 5'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
    n_mismatch = 0;
    n_compared = 0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    void'($urandom(38318));
    rd_chk(`STAT_ADDR, st(0, 0, 1, 0, 0), "status at reset");
    rd_chk(`CTRL_ADDR, 8'h00, "control at reset");
    axi_rd(8'h00, d, r);
    check("unmapped read resp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    axi_wr(8'h00, 8'hff, r);
    check("unmapped write resp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    wr(`BAUD_ADDR, 8'h01);
    wr(`CTRL_ADDR, 8'h10);
    check("pin forced input", {31'h0, pin_oe}, 32'h0);
    check("pull-up kept", {31'h0, pin_pullup}, 32'h1);
    check("pin latch out", {31'h0, pin_out}, 32'h1);
    n_tick = 0;
    repeat (32) @(posedge ref_clk) n_tick += sample_tick;
    check("ticks per bit", n_tick, 32'h10);
    for (int i = 0; i < 5; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      rmt.send({1'b0, b}, 8, 1'b1, BIT_CLKS);
      rd_chk(`STAT_ADDR, st(1, 0, 1, 0, 0), "status after char");
      rd_chk(`DATA_ADDR, b, "received byte");
      rd_chk(`STAT_ADDR, st(0, 0, 1, 0, 0), "status after read");
    end
    $display("test bytes done");
    rmt.send(9'h03c, 8, 1'b0, BIT_CLKS);
    rd_chk(`STAT_ADDR, st(1, 0, 1, 1, 0), "framing fault");
    rd_chk(`DATA_ADDR, 8'h3c, "byte with bad stop");
    wr(`CTRL_ADDR, 8'h00);
    check("pin released", {31'h0, pin_oe}, 32'h1);
    rmt.send(9'h055, 8, 1'b1, BIT_CLKS);
    rd_chk(`STAT_ADDR, st(0, 0, 1, 1, 0), "disabled receiver");
    wr(`CTRL_ADDR, 8'h10);
    rmt.send(9'h066, 8, 1'b1, BIT_CLKS);
    rd_chk(`STAT_ADDR, st(1, 0, 1, 0, 0), "framing cleared");
    rd_chk(`DATA_ADDR, 8'h66, "byte after fault");
    $display("test framing done");
    rmt.send(9'h011, 8, 1'b1, BIT_CLKS);
    rmt.send(9'h022, 8, 1'b1, BIT_CLKS);
    rd_chk(`STAT_ADDR, st(1, 0, 1, 0, 0), "overrun held");
    rd_chk(`DATA_ADDR, 8'h11, "first byte kept");
    rd_chk(`STAT_ADDR, st(0, 0, 1, 0, 1), "overrun shown");
    rmt.send(9'h033, 8, 1'b1, BIT_CLKS);
    rd_chk(`STAT_ADDR, st(1, 0, 1, 0, 0), "overrun cleared");
    rd_chk(`DATA_ADDR, 8'h33, "byte after overrun");
    rmt.glitch(4);
    rd_chk(`STAT_ADDR, st(0, 0, 1, 0, 0), "spike rejected");
    $display("test overrun and noise done");
    wr(`CTRL_ADDR, 8'h14);
    rmt.send(9'h1a5, 9, 1'b1, BIT_CLKS);
    rd_chk(`CTRL_ADDR, 8'h16, "ninth bit set");
    rd_chk(`DATA_ADDR, 8'ha5, "nine-bit low byte");
    rmt.send(9'h05a, 9, 1'b1, BIT_CLKS);
    rd_chk(`CTRL_ADDR, 8'h14, "ninth bit clear");
    rd_chk(`DATA_ADDR, 8'h5a, "nine-bit second byte");
    $display("test nine-bit done");
    global_irq_enable <= 1'b1;
    wr(`CTRL_ADDR, 8'hf0);
    rmt.send(9'h077, 8, 1'b1, BIT_CLKS);
    check("rx irq", {31'h0, rx_done_irq}, 32'h1);
    check("empty irq", {31'h0, tx_empty_irq}, 32'h1);
    rd_chk(`DATA_ADDR, 8'h77, "irq byte");
    repeat (2) @(posedge ref_clk);
    check("rx irq cleared", {31'h0, rx_done_irq}, 32'h0);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("empty irq gated", {31'h0, tx_empty_irq}, 32'h0);
    global_irq_enable <= 1'b1;
    wr(`DATA_ADDR, 8'hc3);
    repeat (2) @(posedge ref_clk);
    check("transmit holding", {24'h0, tx_hold_data}, 32'hc3);
    check("empty irq off", {31'h0, tx_empty_irq}, 32'h0);
    check("data pending", {31'h0, tx_data_pending}, 32'h1);
    rd_chk(`STAT_ADDR, st(0, 0, 0, 0, 0), "empty cleared");
    pulse(0);
    rd_chk(`STAT_ADDR, st(0, 0, 1, 0, 0), "empty set on load");
    check("data pending off", {31'h0, tx_data_pending}, 32'h0);
    pulse(1);
    rd_chk(`STAT_ADDR, st(0, 1, 1, 0, 0), "tx done set");
    check("tx done irq", {31'h0, tx_done_irq}, 32'h1);
    wr(`STAT_ADDR, 8'h40);
    rd_chk(`STAT_ADDR, st(0, 0, 1, 0, 0), "tx done by write");
    pulse(1);
    pulse(2);
    rd_chk(`STAT_ADDR, st(0, 0, 1, 0, 0), "tx done by vector");
    wr(`CTRL_ADDR, 8'h0d);
    wr(`DATA_ADDR, 8'h5e);
    check("transmit ninth bit", {31'h0, tx_hold_ninth}, 32'h1);
    tx_shift_busy <= 1'b1;
    wr(`CTRL_ADDR, 8'h00);
    check("transmitter held on", {31'h0, tx_active}, 32'h1);
    pulse(0);
    tx_shift_busy <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check("transmitter off", {31'h0, tx_active}, 32'h0);
    $display("test interrupts and transmit flags done");
    wrap_up();
  end
endmodule // uart_rx_ctrl_tb
